/* rtl/dsd_decoder.sv */
/*
 Data-space decoder with read-only program-memory window, instruction pointer
 and return stack. Assumes the core issues one access per cycle and the
 program memory answers combinationally to the address it is given.
*/
`timescale 1ns/1ps
module dsd_decoder #(
    parameter int          PM_SIZE = 4096
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire dsd_pkg::dsd_req_t req,
    output logic [7:0]             rdata,
    output logic                   rvalid,
    input  wire dsd_pkg::dsd_flow_t flow,
    input  wire logic              fetch_next,
    output logic [11:0]            instruction_pointer,
    output logic [11:0]            pm_addr,
    input  wire logic [7:0]        pm_rdata,
    input  wire logic              readout_protect,
    input  wire logic              ext_rd,
    input  wire logic [11:0]       ext_addr,
    output logic [7:0]             ext_rdata,
    output logic [2:0]             stack_level
);
    import dsd_pkg::*;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic dsd_sel_t decode(input logic [7:0] a);
        if (a >= ADDR_WIN_LO && a <= ADDR_WIN_HI) begin
            decode = DSD_SEL_WIN;
        end else if (a >= ADDR_RAM_LO && a <= ADDR_RAM_HI) begin
            decode = DSD_SEL_RAM;
        end else if (a == ADDR_IDX_ONE || a == ADDR_IDX_TWO || a == ADDR_SHD_ONE
                     || a == ADDR_SHD_TWO || a == ADDR_ACC) begin
            decode = DSD_SEL_REG;
        end else begin
            decode = DSD_SEL_NONE;
        end
    endfunction : decode

    dsd_sel_t sel;
    assign sel = decode(req.addr);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] ram_q [RAM_BYTES];
    logic [7:0] index_pointer_one_q;
    logic [7:0] index_pointer_two_q;
    logic [7:0] short_direct_one_q;
    logic [7:0] short_direct_two_q;
    logic [7:0] main_accumulator_q;
    logic [5:0] window_base_bits_q;
    logic [5:0] ram_idx;
    assign ram_idx = 6'(req.addr - ADDR_RAM_LO);

    always_ff @(posedge mclk) begin
        if (req.wr && sel == DSD_SEL_RAM) begin
            ram_q[ram_idx] <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (req.wr) begin
            unique case (req.addr)
                ADDR_IDX_ONE: index_pointer_one_q <= req.wdata;
                ADDR_IDX_TWO: index_pointer_two_q <= req.wdata;
                ADDR_SHD_ONE: short_direct_one_q  <= req.wdata;
                ADDR_SHD_TWO: short_direct_two_q  <= req.wdata;
                ADDR_ACC:     main_accumulator_q  <= req.wdata;
                default: ;
            endcase
        end
    end

    // Window base: no reset term, top two bits dropped
    always_ff @(posedge mclk) begin
        if (req.wr && req.addr == ADDR_WIN_BASE) begin
            window_base_bits_q <= req.wdata[5:0];
        end
    end

    // Marks the base as loaded since reset; only the checks read it
    logic base_loaded_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            base_loaded_q <= 1'b0;
        end else if (req.wr && req.addr == ADDR_WIN_BASE) begin
            base_loaded_q <= 1'b1;
        end
    end

    // ****************************************
    // Program memory address
    // ****************************************
    logic [11:0] win_addr;
    logic [11:0] ip_q;
    assign win_addr = {window_base_bits_q, req.addr[WIN_LOW_BITS-1:0]};

    // Window reads take the port in the access cycle, then readout, then fetch
    always_comb begin
        if (req.rd && sel == DSD_SEL_WIN) begin
            pm_addr = win_addr;
        end else if (ext_rd) begin
            pm_addr = ext_addr;
        end else begin
            pm_addr = ip_q;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [7:0] rd_d;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    always_comb begin
        rd_d = RESERVED_RD;
        unique case (sel)
            DSD_SEL_WIN: rd_d = pm_rdata;
            DSD_SEL_RAM: rd_d = ram_q[ram_idx];
            DSD_SEL_REG: begin
                unique case (req.addr)
                    ADDR_IDX_ONE: rd_d = index_pointer_one_q;
                    ADDR_IDX_TWO: rd_d = index_pointer_two_q;
                    ADDR_SHD_ONE: rd_d = short_direct_one_q;
                    ADDR_SHD_TWO: rd_d = short_direct_two_q;
                    default:      rd_d = main_accumulator_q;
                endcase
            end
            DSD_SEL_NONE: rd_d = RESERVED_RD;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd) begin
                rdata_q <= rd_d;
            end
        end
    end

    // ****************************************
    // Instruction pointer and stack
    // ****************************************
    logic [2:0]  lvl;
    logic [11:0] stack_top;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ip_q <= IP_RESET;
        end else if (flow.load || flow.push) begin
            ip_q <= flow.target;
        end else if (flow.pop) begin
            ip_q <= stack_top;
        end else if (fetch_next) begin
            ip_q <= ip_q + 12'h001;
        end
    end

    dsd_stack #(.DEPTH(STACK_DEPTH), .W(PM_ADDR_W)) u_stack (
        .mclk     (mclk),
        .reset    (reset),
        .push     (flow.push),
        .pop      (flow.pop && !flow.push),
        .push_val (ip_q),
        .top      (stack_top),
        .level    (lvl)
    );

    // ****************************************
    // External readout
    // ****************************************
    logic [7:0] ext_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ext_q <= 8'h00;
        end else if (ext_rd) begin
            ext_q <= readout_protect ? 8'h00 : pm_rdata;
        end
    end

    logic [2:0] lvl_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lvl_q <= 3'h0;
        end else begin
            lvl_q <= lvl;
        end
    end

    assign rdata               = rdata_q;
    assign rvalid              = rvalid_q;
    assign instruction_pointer = ip_q;
    assign ext_rdata           = ext_q;
    assign stack_level         = lvl_q;

    // ****************************************
    // Checks
    // ****************************************
    win_addr_a: assert property (@(posedge mclk) disable iff (reset)
        req.rd && sel == DSD_SEL_WIN |-> pm_addr[5:0] == req.addr[5:0])
        else $error("window low bits wrong");
    win_data_a: assert property (@(posedge mclk) disable iff (reset)
        req.rd && sel == DSD_SEL_WIN |=> rdata == $past(pm_rdata))
        else $error("window data not returned");
    base_hold_a: assert property (@(posedge mclk) disable iff (reset)
        base_loaded_q && !(req.wr && req.addr == ADDR_WIN_BASE)
        |=> $stable(window_base_bits_q))
        else $error("window base changed without write");
    base_mask_a: assert property (@(posedge mclk) disable iff (reset)
        req.wr && req.addr == ADDR_WIN_BASE |=> window_base_bits_q == $past(req.wdata[5:0]))
        else $error("window base load wrong");
    wo_read_a: assert property (@(posedge mclk) disable iff (reset)
        req.rd && (req.addr == ADDR_WIN_BASE || req.addr == ADDR_WO_ONE)
        |=> rdata == RESERVED_RD)
        else $error("write-only readback");
    protect_a: assert property (@(posedge mclk) disable iff (reset)
        ext_rd && readout_protect |=> ext_rdata == 8'h00)
        else $error("protected readout leaked");
    ip_step_a: assert property (@(posedge mclk) disable iff (reset)
        fetch_next && !flow.load && !flow.push && !flow.pop
        |=> instruction_pointer == 12'($past(instruction_pointer) + 12'h001))
        else $error("pointer did not step");
    sequence call_s;
        flow.push && !flow.pop;
    endsequence : call_s
    sequence return_s;
        flow.pop && !flow.push && !flow.load;
    endsequence : return_s
    ret_a: assert property (@(posedge mclk) disable iff (reset)
        call_s ##1 return_s
        |=> instruction_pointer == $past(instruction_pointer, 2))
        else $error("return address lost");
endmodule : dsd_decoder

/* rtl/dsd_pkg.sv */
/*
 Package for the data-space decoder with program-memory window.
 Assumes a single clock domain and a core that drives address, data and strobes.
*/
package dsd_pkg;
    localparam logic [7:0]  ADDR_WIN_LO   = 8'h40;
    localparam logic [7:0]  ADDR_WIN_HI   = 8'h7f;
    localparam logic [7:0]  ADDR_IDX_ONE  = 8'h80;
    localparam logic [7:0]  ADDR_IDX_TWO  = 8'h81;
    localparam logic [7:0]  ADDR_SHD_ONE  = 8'h82;
    localparam logic [7:0]  ADDR_SHD_TWO  = 8'h83;
    localparam logic [7:0]  ADDR_RAM_LO   = 8'h84;
    localparam logic [7:0]  ADDR_RAM_HI   = 8'hbf;
    localparam logic [7:0]  ADDR_WO_ONE   = 8'hc8;
    localparam logic [7:0]  ADDR_WIN_BASE = 8'hc9;
    localparam logic [7:0]  ADDR_ACC      = 8'hff;
    localparam int          WIN_LOW_BITS  = 6;
    localparam int          PM_ADDR_W     = 12;
    localparam int          STACK_DEPTH   = 6;
    localparam int          RAM_BYTES     = 60;
    localparam logic [7:0]  RESERVED_RD   = 8'hff;
    localparam logic [11:0] IP_RESET      = 12'hffe;

    typedef enum logic [1:0] {
        DSD_SEL_NONE = 2'h0,
        DSD_SEL_REG  = 2'h1,
        DSD_SEL_RAM  = 2'h3,
        DSD_SEL_WIN  = 2'h2
    } dsd_sel_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       rd;
        logic       wr;
    } dsd_req_t;

    typedef struct packed {
        logic        push;
        logic        pop;
        logic        load;
        logic [11:0] target;
    } dsd_flow_t;
endpackage : dsd_pkg

/* rtl/dsd_stack.sv */
/*
 Return-address stack of six 12-bit levels.
 Assumes the core never pushes past six levels nor pops an empty stack.
*/
`timescale 1ns/1ps
module dsd_stack #(
    parameter int DEPTH = 6,
    parameter int W     = 12
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] push_val,
    output logic      [W-1:0] top,
    output logic      [2:0]   level
);
    logic [W-1:0] lvl_q [DEPTH];
    logic [2:0]   level_q;

    // Shift register of return addresses
    always_ff @(posedge mclk) begin
        if (push) begin
            lvl_q[0] <= push_val;
            for (int i = 1; i < DEPTH; i++) begin
                lvl_q[i] <= lvl_q[i-1];
            end
        end else if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                lvl_q[i] <= lvl_q[i+1];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            level_q <= 3'h0;
        end else if (push && level_q != 3'(DEPTH)) begin
            level_q <= level_q + 3'h1;
        end else if (pop && !push && level_q != 3'h0) begin
            level_q <= level_q - 3'h1;
        end
    end

    assign top   = lvl_q[0];
    assign level = level_q;
endmodule : dsd_stack

/* sim/dsd_decoder_tb.sv */
/*
 Self-checking bench for the data-space decoder.
 Assumes a combinational program memory model on pm_addr.
*/
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module dsd_decoder_tb;
    import dsd_pkg::*;
    logic       mclk = 0, reset = 1, fetch_next = 0, readout_protect = 0, ext_rd = 0;
    dsd_req_t   req = '0;
    dsd_flow_t  flow = '0;
    logic [11:0] ext_addr = '0, ip, pm_addr;
    logic [7:0] rdata, pm_rdata, ext_rdata;
    logic       rvalid;
    logic [2:0] stack_level;
    int         num_errors = 0, samples_checked = 0, cycles = 0, i;
    logic [7:0] wb [4] = '{8'hc2, 8'h00, 8'h3f, 8'h15};
    logic [7:0] wa [4] = '{8'h45, 8'h40, 8'h7f, 8'h60};
    logic [11:0] wp [4] = '{12'h085, 12'h000, 12'hfff, 12'h560};
    logic [7:0] ra [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hbf, 8'hff};

    dsd_decoder #(.PM_SIZE(4096)) i_dsd_decoder (.mclk(mclk), .reset(reset), .req(req),
        .rdata(rdata), .rvalid(rvalid), .flow(flow), .fetch_next(fetch_next),
        .instruction_pointer(ip), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .readout_protect(readout_protect), .ext_rd(ext_rd), .ext_addr(ext_addr),
        .ext_rdata(ext_rdata), .stack_level(stack_level));
    dsd_pm_model i_dsd_pm_model (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end

    function automatic logic [7:0] pmv(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction : pmv
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1 req = '{addr: a, wdata: d, rd: 1'b0, wr: 1'b1};
        @(posedge mclk) #1 req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [11:0] pa);
        @(posedge mclk) #1 req = '{addr: a, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
        #1 if (a >= ADDR_WIN_LO && a <= ADDR_WIN_HI) check(pm_addr, pa);
        @(posedge mclk) #1 req.rd = 1'b0;
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask : rd
    task automatic fl(input logic [2:0] ppl, input logic [11:0] t, input logic nx);
        @(posedge mclk) #1 flow = '{push: ppl[2], pop: ppl[1], load: ppl[0], target: t};
        fetch_next = nx;
        @(posedge mclk) #1 flow = '0;
        fetch_next = 1'b0;
        // Depth output trails the stack by one register
        @(posedge mclk);
        #1;
    endtask : fl
    task automatic ext(input logic prot, input logic [11:0] a, input logic [7:0] exp);
        @(posedge mclk) #1 readout_protect = prot;
        ext_rd = 1'b1;
        ext_addr = a;
        @(posedge mclk) #1 ext_rd = 1'b0;
        check(ext_rdata, exp);
    endtask : ext
    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5) @(posedge mclk);
        #1 reset = 1'b0;
        check(ip, IP_RESET);
        check(stack_level, 3'h0);
        check({rvalid, rdata, ext_rdata}, 17'h0);
        // Base is always written before the first window read, its RAM copy first
        for (i = 0; i < 4; i++) begin
            wr(ADDR_RAM_LO, wb[i]);
            wr(ADDR_WIN_BASE, wb[i]);
            rd(wa[i], pmv(wp[i]), wp[i]);
        end
        wr(wa[0], 8'haa);
        rd(wa[0], pmv(12'h545), 12'h545);
        wr(ADDR_WO_ONE, 8'h5a);
        rd(ADDR_WIN_BASE, RESERVED_RD, 12'h0);
        rd(ADDR_WO_ONE, RESERVED_RD, 12'h0);
        rd(8'h00, RESERVED_RD, 12'h0);
        rd(8'h3f, RESERVED_RD, 12'h0);
        for (i = 0; i < 7; i++) wr(ra[i], ra[i] ^ 8'h5a);
        for (i = 0; i < 7; i++) rd(ra[i], ra[i] ^ 8'h5a, 12'h0);
        wr(ADDR_WIN_BASE, 8'h0a);
        @(posedge mclk) #1 reset = 1'b1;
        @(posedge mclk) #1 reset = 1'b0;
        rd(8'h41, pmv(12'h281), 12'h281);
        fl(3'b001, 12'h100, 1'b0);
        check(ip, 12'h100);
        fl(3'b000, 12'h000, 1'b1);
        check(ip, 12'h101);
        fl(3'b100, 12'h200, 1'b0);
        check({stack_level, 1'b0, ip}, {3'h1, 1'b0, 12'h200});
        fl(3'b010, 12'h000, 1'b0);
        check({stack_level, 1'b0, ip}, {3'h0, 1'b0, 12'h101});
        for (i = 0; i < 6; i++) fl(3'b100, 12'h300 + 12'(i), 1'b0);
        check({stack_level, 1'b0, ip}, {3'h6, 1'b0, 12'h305});
        fl(3'b010, 12'h000, 1'b0);
        check({stack_level, 1'b0, ip}, {3'h5, 1'b0, 12'h304});
        // Call straight followed by return
        @(posedge mclk) #1 flow = '{push: 1'b1, pop: 1'b0, load: 1'b0, target: 12'h3a0};
        @(posedge mclk) #1 flow = '{push: 1'b0, pop: 1'b1, load: 1'b0, target: 12'h000};
        @(posedge mclk) #1 flow = '0;
        @(posedge mclk) #1 check({stack_level, 1'b0, ip}, {3'h5, 1'b0, 12'h304});
        ext(1'b0, 12'h7a5, pmv(12'h7a5));
        ext(1'b1, 12'h7a5, 8'h00);
        test_done();
    end
endmodule : dsd_decoder_tb

/* sim/dsd_pm_model.sv */
/*
 Program memory model answering combinationally to the address it is given.
 Assumes the decoder drives pm_addr and reads pm_rdata in the same cycle.
*/
`timescale 1ns/1ps
// ****************************************
// Program memory contents
// ****************************************
module dsd_pm_model (
    input  wire logic [11:0] pm_addr,
    output logic      [7:0]  pm_rdata
);
    // Every byte up to 0FFFh answers
    assign pm_rdata = pm_addr[7:0] ^ {pm_addr[11:8], pm_addr[11:8]};
endmodule : dsd_pm_model
